//--- rtl/pwm_phase_freq_vin_config.sv
// Phase, range, share-clock, frequency and input-voltage command block
`timescale 1ns/1ps
module pwm_phase_freq_vin_config (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [1:0]  run_pin,
  input  wire logic        pll_locked_pin,
  input  wire logic [1:0]  chan_on_cmd,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [1:0]  cmd_nbytes,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        clear_faults,
  input  wire logic        vin_adc_valid,
  input  wire logic [15:0] vin_adc_code,
  output      logic        rsp_valid_q,
  output      logic [15:0] rsp_data_q,
  output      logic [1:0]  rsp_nbytes_q,
  output      logic [8:0]  ch0_phase_deg_q,
  output      logic [8:0]  ch1_phase_deg_q,
  output      logic        channel0_range_select_q,
  output      logic        channel1_range_select_q,
  output      logic [15:0] switching_freq_word_q,
  output      logic        ext_osc_sel_q,
  output      logic        share_clk_o_q,
  output      logic        share_clk_oe_q,
  output      logic [1:0]  conversion_enable_q,
  output      logic        busy_fault_q,
  output      logic        cml_fault_q,
  output      logic        pll_unlock_q,
  output      logic        vin_ov_fault_q,
  output      logic        vin_uv_warn_q
);

  // ------------------------------------------------------------
  // Registers and synchronised inputs
  // ------------------------------------------------------------
  logic [7:0]              phase_range_share_config_q;
  logic [15:0]             input_turn_on_threshold_q;
  logic [15:0]             input_turn_off_threshold_q;
  logic [15:0]             input_overvoltage_fault_limit_q;
  logic [15:0]             input_undervoltage_warn_limit_q;
  logic [15:0]             vin_sample_q;
  logic                    sample_new_q;
  logic                    power_seen_q;
  pwm_cfg_pkg::vin_state_t vin_state_q;
  pwm_cfg_pkg::vin_state_t vin_state_d;
  logic [1:0]              run_sync;
  logic                    pll_locked_sync;
  logic                    freq_supported;
  logic                    freq_ext;

  level_sync #(
    .W (3)
  ) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in ({pll_locked_pin, run_pin}),
    .sync_out ({pll_locked_sync, run_sync})
  );

  freq_table u_freq (
    .word      (cmd_wdata),
    .supported (freq_supported),
    .ext_osc   (freq_ext)
  );

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  logic wr;
  logic rd;
  logic hit_phase;
  logic hit_freq;
  logic hit_word;
  logic bytes_ok;
  logic running;
  logic phase_acc;
  logic freq_acc;
  logic busy_set;
  logic cml_set;

  assign wr        = cmd_valid & cmd_write;
  assign rd        = cmd_valid & ~cmd_write;
  assign hit_phase = (cmd_code == pwm_cfg_pkg::CMD_PHASE_CFG);
  assign hit_freq  = (cmd_code == pwm_cfg_pkg::CMD_FREQ);
  assign hit_word  = hit_freq
                   | (cmd_code == pwm_cfg_pkg::CMD_INPUT_TURN_ON_THRESHOLD)
                   | (cmd_code == pwm_cfg_pkg::CMD_INPUT_TURN_OFF_THRESHOLD)
                   | (cmd_code == pwm_cfg_pkg::CMD_VIN_OV)
                   | (cmd_code == pwm_cfg_pkg::CMD_VIN_UV);
  // Byte count checked before anything is stored
  assign bytes_ok  = hit_phase ? (cmd_nbytes == pwm_cfg_pkg::BYTES_ONE)
                               : (cmd_nbytes == pwm_cfg_pkg::BYTES_TWO);
  // Off means either run input low or channel commanded off
  assign running   = |(run_sync & chan_on_cmd);
  assign phase_acc = wr & hit_phase & bytes_ok & ~running
                   & (cmd_wdata[2:0] != pwm_cfg_pkg::PHASE_BAD);
  assign freq_acc  = wr & hit_freq & bytes_ok & ~running & freq_supported;
  assign busy_set  = wr & (hit_phase | hit_freq) & bytes_ok & running;
  assign cml_set   = wr & (hit_phase | hit_word)
                   & (~bytes_ok | (~running & ~phase_acc & ~freq_acc
                                   & (hit_phase | hit_freq)));

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      phase_range_share_config_q <= pwm_cfg_pkg::RST_PHASE_CFG;
    end else if (phase_acc) begin
      // Reserved top bit always stored as zero
      phase_range_share_config_q <= cmd_wdata[7:0] & pwm_cfg_pkg::PHASE_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      switching_freq_word_q <= pwm_cfg_pkg::RST_FREQ;
      ext_osc_sel_q         <= 1'b0;
    end else if (freq_acc) begin
      switching_freq_word_q <= cmd_wdata;
      ext_osc_sel_q         <= freq_ext;
    end
  end

  // Threshold words are not gated by run state
  always_ff @(posedge clk) begin
    if (srst) begin
      input_turn_on_threshold_q       <= pwm_cfg_pkg::RST_INPUT_TURN_ON_THRESHOLD;
      input_turn_off_threshold_q      <= pwm_cfg_pkg::RST_INPUT_TURN_OFF_THRESHOLD;
      input_overvoltage_fault_limit_q <= pwm_cfg_pkg::RST_VIN_OV;
      input_undervoltage_warn_limit_q <= pwm_cfg_pkg::RST_VIN_UV;
    end else if (wr && bytes_ok) begin
      unique case (cmd_code)
        pwm_cfg_pkg::CMD_INPUT_TURN_ON_THRESHOLD:  input_turn_on_threshold_q       <= cmd_wdata;
        pwm_cfg_pkg::CMD_INPUT_TURN_OFF_THRESHOLD: input_turn_off_threshold_q      <= cmd_wdata;
        pwm_cfg_pkg::CMD_VIN_OV:  input_overvoltage_fault_limit_q <= cmd_wdata;
        pwm_cfg_pkg::CMD_VIN_UV:  input_undervoltage_warn_limit_q <= cmd_wdata;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read answers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_valid_q  <= 1'b0;
      rsp_data_q   <= 16'h0000;
      rsp_nbytes_q <= 2'h0;
    end else begin
      rsp_valid_q  <= rd & (hit_phase | hit_word);
      rsp_nbytes_q <= hit_phase ? pwm_cfg_pkg::BYTES_ONE : pwm_cfg_pkg::BYTES_TWO;
      unique case (cmd_code)
        pwm_cfg_pkg::CMD_PHASE_CFG: rsp_data_q <= {8'h00, phase_range_share_config_q};
        pwm_cfg_pkg::CMD_FREQ:      rsp_data_q <= switching_freq_word_q;
        pwm_cfg_pkg::CMD_INPUT_TURN_ON_THRESHOLD:    rsp_data_q <= input_turn_on_threshold_q;
        pwm_cfg_pkg::CMD_INPUT_TURN_OFF_THRESHOLD:   rsp_data_q <= input_turn_off_threshold_q;
        pwm_cfg_pkg::CMD_VIN_OV:    rsp_data_q <= input_overvoltage_fault_limit_q;
        pwm_cfg_pkg::CMD_VIN_UV:    rsp_data_q <= input_undervoltage_warn_limit_q;
        default:                    rsp_data_q <= 16'h0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Phase and range outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ch0_phase_deg_q         <= 9'h000;
      ch1_phase_deg_q         <= 9'h0B4;
      channel0_range_select_q <= 1'b0;
      channel1_range_select_q <= 1'b0;
    end else begin
      {ch0_phase_deg_q, ch1_phase_deg_q} <=
        pwm_cfg_pkg::phase_deg(phase_range_share_config_q[2:0]);
      channel0_range_select_q <=
        phase_range_share_config_q[pwm_cfg_pkg::CH0_RANGE_BIT];
      channel1_range_select_q <=
        phase_range_share_config_q[pwm_cfg_pkg::CH1_RANGE_BIT];
    end
  end

  // ------------------------------------------------------------
  // Input voltage monitor
  // ------------------------------------------------------------
  logic signed [47:0] vin_val;
  logic               share_en;

  assign vin_val  = pwm_cfg_pkg::l11_value(vin_sample_q);
  assign share_en = phase_range_share_config_q[pwm_cfg_pkg::SHARE_EN_BIT];

  always_ff @(posedge clk) begin
    if (srst) begin
      vin_sample_q <= 16'h0000;
      sample_new_q <= 1'b0;
    end else begin
      sample_new_q <= vin_adc_valid;
      if (vin_adc_valid) begin
        vin_sample_q <= vin_adc_code;
      end
    end
  end

  // Thresholds only act on fresh samples; the converter sets the latency
  always_comb begin
    vin_state_d = vin_state_q;
    unique case (vin_state_q)
      pwm_cfg_pkg::VIN_WAIT: begin
        if (sample_new_q &&
            vin_val >= pwm_cfg_pkg::l11_value(input_turn_on_threshold_q)) begin
          vin_state_d = pwm_cfg_pkg::VIN_GOOD;
        end
      end
      pwm_cfg_pkg::VIN_GOOD: begin
        if (sample_new_q &&
            vin_val <= pwm_cfg_pkg::l11_value(input_turn_off_threshold_q)) begin
          vin_state_d = pwm_cfg_pkg::VIN_WAIT;
        end
      end
      default: vin_state_d = pwm_cfg_pkg::VIN_WAIT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      vin_state_q  <= pwm_cfg_pkg::VIN_WAIT;
      power_seen_q <= 1'b0;
    end else begin
      vin_state_q <= vin_state_d;
      if (vin_state_q == pwm_cfg_pkg::VIN_GOOD) begin
        power_seen_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      conversion_enable_q <= 2'b00;
    end else begin
      conversion_enable_q <= run_sync & chan_on_cmd
                           & {2{vin_state_q == pwm_cfg_pkg::VIN_GOOD}};
    end
  end

  // Share clock is open drain: output always low, enable means pulling
  always_ff @(posedge clk) begin
    if (srst) begin
      share_clk_o_q  <= 1'b0;
      share_clk_oe_q <= 1'b1;
    end else begin
      share_clk_o_q <= 1'b0;
      if (share_en) begin
        share_clk_oe_q <= (vin_state_q == pwm_cfg_pkg::VIN_WAIT);
      end else begin
        share_clk_oe_q <= ~power_seen_q;
      end
    end
  end

  // ------------------------------------------------------------
  // Sticky status flags; a set in the clearing cycle wins
  // ------------------------------------------------------------
  logic ov_set;
  logic uv_set;

  assign ov_set = sample_new_q
                & (vin_val > pwm_cfg_pkg::l11_value(input_overvoltage_fault_limit_q));
  assign uv_set = sample_new_q
                & (vin_val <= pwm_cfg_pkg::l11_value(input_undervoltage_warn_limit_q));

  always_ff @(posedge clk) begin
    if (srst) begin
      busy_fault_q   <= 1'b0;
      cml_fault_q    <= 1'b0;
      vin_ov_fault_q <= 1'b0;
      vin_uv_warn_q  <= 1'b0;
    end else begin
      busy_fault_q   <= busy_set | (busy_fault_q & ~clear_faults);
      cml_fault_q    <= cml_set | (cml_fault_q & ~clear_faults);
      vin_ov_fault_q <= ov_set | (vin_ov_fault_q & ~clear_faults);
      vin_uv_warn_q  <= uv_set | (vin_uv_warn_q & ~clear_faults);
    end
  end

  // Unlock follows an accepted frequency change; it drops only once lock is seen again
  always_ff @(posedge clk) begin
    if (srst) begin
      pll_unlock_q <= 1'b0;
    end else begin
      pll_unlock_q <= freq_acc | (pll_unlock_q & ~pll_locked_sync);
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  AST_RESET_VALUES: assert property ($past(srst) |->
    phase_range_share_config_q == pwm_cfg_pkg::RST_PHASE_CFG
    && switching_freq_word_q == pwm_cfg_pkg::RST_FREQ)
    else $error("reset values wrong");

  AST_PHASE_BUSY: assert property (wr && hit_phase && bytes_ok && running
    |=> busy_fault_q && $stable(phase_range_share_config_q))
    else $error("phase write while running not refused");

  AST_FREQ_BUSY: assert property (wr && hit_freq && bytes_ok && running
    |=> busy_fault_q && $stable(switching_freq_word_q) && !$rose(pll_unlock_q))
    else $error("frequency write while running not refused");

  AST_PHASE_DEG: assert property (phase_acc && cmd_wdata[2:0] == 3'h5
    |=> ##1 ch0_phase_deg_q == 9'h03C && ch1_phase_deg_q == 9'h0F0)
    else $error("phase 101b not 60/240");

  AST_RANGE0: assert property (phase_acc
    |=> ##1 channel0_range_select_q == $past(cmd_wdata[6], 2))
    else $error("channel0 range not taken");

  AST_RANGE1: assert property (phase_acc
    |=> ##1 channel1_range_select_q == $past(cmd_wdata[5], 2))
    else $error("channel1 range not taken");

  AST_SHARE_HOLD: assert property (share_en && vin_state_q == pwm_cfg_pkg::VIN_WAIT
    |=> share_clk_oe_q && !share_clk_o_q)
    else $error("share clock not held low");

  AST_SHARE_FREE: assert property (!share_en && power_seen_q
    |=> !share_clk_oe_q)
    else $error("share clock pulled after power-up");

  AST_BYTE_COUNT: assert property (wr && hit_phase && !bytes_ok
    |=> cml_fault_q && $stable(phase_range_share_config_q))
    else $error("bad byte count stored");

  AST_FREQ_BAD: assert property (wr && hit_freq && bytes_ok && !running
    && !freq_supported |=> cml_fault_q && $stable(switching_freq_word_q))
    else $error("unsupported frequency stored");

  AST_PLL_UNLOCK: assert property (freq_acc |=> pll_unlock_q)
    else $error("no unlock after frequency change");

  AST_OV_FAULT: assert property (ov_set |=> vin_ov_fault_q)
    else $error("overvoltage not flagged");

  AST_UV_WARN: assert property (uv_set |=> vin_uv_warn_q)
    else $error("undervoltage not flagged");

  AST_CONV_GATE: assert property (vin_state_q == pwm_cfg_pkg::VIN_WAIT
    |=> conversion_enable_q == 2'b00)
    else $error("conversion without input");

  COV_FREQ_CHANGE: cover property (freq_acc ##1 pll_unlock_q ##[1:20] !pll_unlock_q);
  COV_BUSY:        cover property (busy_set);
  COV_POWER_UP:    cover property (vin_state_q == pwm_cfg_pkg::VIN_WAIT
                                   ##1 vin_state_q == pwm_cfg_pkg::VIN_GOOD);

endmodule

//--- rtl/pwm_cfg_pkg.sv
// Constants, types and helpers shared by the phase, frequency and input-voltage block
package pwm_cfg_pkg;

  // ------------------------------------------------------------
  // Command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_PHASE_CFG = 8'hF5;
  localparam logic [7:0] CMD_FREQ      = 8'h33;
  localparam logic [7:0] CMD_INPUT_TURN_ON_THRESHOLD    = 8'h35;
  localparam logic [7:0] CMD_INPUT_TURN_OFF_THRESHOLD   = 8'h36;
  localparam logic [7:0] CMD_VIN_OV    = 8'h55;
  localparam logic [7:0] CMD_VIN_UV    = 8'h58;

  // ------------------------------------------------------------
  // Reset values, byte counts, fields
  // ------------------------------------------------------------
  localparam logic [7:0]  RST_PHASE_CFG = 8'h10;
  localparam logic [15:0] RST_FREQ      = 16'hFABC;
  localparam logic [15:0] RST_INPUT_TURN_ON_THRESHOLD    = 16'hCB40;
  localparam logic [15:0] RST_INPUT_TURN_OFF_THRESHOLD   = 16'hCB00;
  localparam logic [15:0] RST_VIN_OV    = 16'hD3E0;
  localparam logic [15:0] RST_VIN_UV    = 16'hCB26;
  localparam logic [1:0]  BYTES_ONE     = 2'h1;
  localparam logic [1:0]  BYTES_TWO     = 2'h2;
  localparam int          CH0_RANGE_BIT = 6;
  localparam int          CH1_RANGE_BIT = 5;
  localparam int          SHARE_EN_BIT  = 4;
  localparam logic [7:0]  PHASE_WMASK   = 8'h7F;
  localparam logic [2:0]  PHASE_BAD     = 3'h7;

  // ------------------------------------------------------------
  // Supported frequency words
  // ------------------------------------------------------------
  localparam logic [15:0] FREQ_EXT  = 16'h0000;
  localparam logic [15:0] FREQ_250  = 16'hF3E8;
  localparam logic [15:0] FREQ_350  = 16'hFABC;
  localparam logic [15:0] FREQ_425  = 16'hFB52;
  localparam logic [15:0] FREQ_500  = 16'hFBE8;
  localparam logic [15:0] FREQ_575  = 16'h023F;
  localparam logic [15:0] FREQ_650  = 16'h028A;
  localparam logic [15:0] FREQ_750  = 16'h02EE;
  localparam logic [15:0] FREQ_1000 = 16'h03E8;

  typedef enum logic [1:0] {
    VIN_WAIT = 2'b01,
    VIN_GOOD = 2'b10
  } vin_state_t;

  // Linear 5s/11s word scaled by 2^16 so every exponent compares as an integer
  function automatic logic signed [47:0] l11_value(input logic [15:0] w);
    logic signed [47:0] m;
    m = 48'(signed'(w[10:0]));
    return m <<< (w[15:11] ^ 5'h10);
  endfunction

  // Offsets in degrees, channel0 in the upper half
  function automatic logic [17:0] phase_deg(input logic [2:0] code);
    logic [17:0] r;
    r = {9'h000, 9'h0B4};
    unique case (code)
      3'h0: r = {9'h000, 9'h0B4};
      3'h1: r = {9'h05A, 9'h10E};
      3'h2: r = {9'h000, 9'h0F0};
      3'h3: r = {9'h000, 9'h078};
      3'h4: r = {9'h078, 9'h0F0};
      3'h5: r = {9'h03C, 9'h0F0};
      3'h6: r = {9'h078, 9'h12C};
      3'h7: r = {9'h000, 9'h0B4};
    endcase
    return r;
  endfunction

endpackage

//--- rtl/level_sync.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] async_in,
  output      logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

//--- rtl/freq_table.sv
// Lookup of the supported switching-frequency words
`timescale 1ns/1ps
module freq_table (
  input  wire logic [15:0] word,
  output      logic        supported,
  output      logic        ext_osc
);

  always_comb begin
    ext_osc = (word == pwm_cfg_pkg::FREQ_EXT);
    unique case (word)
      pwm_cfg_pkg::FREQ_EXT,
      pwm_cfg_pkg::FREQ_250,
      pwm_cfg_pkg::FREQ_350,
      pwm_cfg_pkg::FREQ_425,
      pwm_cfg_pkg::FREQ_500,
      pwm_cfg_pkg::FREQ_575,
      pwm_cfg_pkg::FREQ_650,
      pwm_cfg_pkg::FREQ_750,
      pwm_cfg_pkg::FREQ_1000: supported = 1'b1;
      default:                supported = 1'b0;
    endcase
  end

endmodule

//--- testbench/pmbus_host_model.sv
// Host model driving the block's command port
`timescale 1ns/1ps
module pmbus_host_model (
  input  wire logic        clk,
  input  wire logic        rsp_valid_q,
  input  wire logic [15:0] rsp_data_q,
  input  wire logic [1:0]  rsp_nbytes_q,
  output      logic        cmd_valid = 1'b0,
  output      logic        cmd_write = 1'b0,
  output      logic [7:0]  cmd_code = 8'h00,
  output      logic [1:0]  cmd_nbytes = 2'h0,
  output      logic [15:0] cmd_wdata = 16'h0000
);
  // ------------------------------------------------------------
  // Transfers
  // ------------------------------------------------------------
  // Count follows the command; bad gives the wrong count on purpose
  task automatic send(input logic [7:0] c, input logic w, input logic [15:0] d,
                      input logic bad);
    @(posedge clk);
    cmd_valid  <= 1'b1;
    cmd_write  <= w;
    cmd_code   <= c;
    cmd_nbytes <= ((c == 8'hF5) != bad) ? 2'h1 : 2'h2;
    cmd_wdata  <= d;
    @(posedge clk);
    cmd_valid  <= 1'b0;
    // Stale data would hide a late capture
    cmd_wdata  <= ~d;
  endtask

  task automatic read(input logic [7:0] c, output logic [15:0] d, output logic [1:0] n,
                      output logic got);
    send(c, 1'b0, 16'h0000, 1'b0);
    got = 1'b0;
    for (int i = 0; i < 3 && !got; i++) begin
      #1;
      got = (rsp_valid_q === 1'b1);
      d = rsp_data_q;
      n = rsp_nbytes_q;
      if (!got) @(posedge clk);
    end
  endtask
endmodule

//--- testbench/test_pwm_phase_freq_vin_config.sv
// Self-checking bench for the phase, frequency and input-voltage block
`timescale 1ns/1ps
module test_pwm_phase_freq_vin_config;
  logic        clk, srst, pll_locked_pin, clear_faults, vin_adc_valid, cmd_valid, cmd_write;
  logic        rsp_valid_q, ch0_rng, ch1_rng, ext_osc, share_o, share_oe;
  logic        busy_f, cml_f, pll_unl, ov_f, uv_w;
  logic [1:0]  run_pin, chan_on_cmd, cmd_nbytes, rsp_nbytes_q, conv_en;
  logic [7:0]  cmd_code;
  logic [15:0] vin_adc_code, cmd_wdata, rsp_data_q, freq_word;
  logic [8:0]  ch0_deg, ch1_deg;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cycles = 0;

  pwm_phase_freq_vin_config i_pwm_phase_freq_vin_config (
    .clk(clk), .srst(srst), .run_pin(run_pin), .pll_locked_pin(pll_locked_pin),
    .chan_on_cmd(chan_on_cmd), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_nbytes(cmd_nbytes), .cmd_wdata(cmd_wdata),
    .clear_faults(clear_faults), .vin_adc_valid(vin_adc_valid), .vin_adc_code(vin_adc_code),
    .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q), .rsp_nbytes_q(rsp_nbytes_q),
    .ch0_phase_deg_q(ch0_deg), .ch1_phase_deg_q(ch1_deg),
    .channel0_range_select_q(ch0_rng), .channel1_range_select_q(ch1_rng),
    .switching_freq_word_q(freq_word), .ext_osc_sel_q(ext_osc), .share_clk_o_q(share_o),
    .share_clk_oe_q(share_oe), .conversion_enable_q(conv_en), .busy_fault_q(busy_f),
    .cml_fault_q(cml_f), .pll_unlock_q(pll_unl), .vin_ov_fault_q(ov_f), .vin_uv_warn_q(uv_w));

  pmbus_host_model i_pmbus_host_model (
    .clk(clk), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
    .rsp_nbytes_q(rsp_nbytes_q), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_nbytes(cmd_nbytes), .cmd_wdata(cmd_wdata));

  // ------------------------------------------------------------
  // Clock, reset and checks
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Generous ceiling; the whole run needs under four hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic bad);
    i_pmbus_host_model.send(c, 1'b1, d, bad);
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] e, input logic [1:0] en);
    logic [15:0] d;
    logic [1:0]  n;
    logic        g;
    i_pmbus_host_model.read(c, d, n, g);
    check(16'(g), 16'h0001);
    check(d, e);
    check(16'(n), 16'(en));
  endtask

  task automatic defaults();
    rd(8'hF5, 16'h0010, 2'h1);
    rd(8'h33, 16'hFABC, 2'h2);
    rd(8'h35, 16'hCB40, 2'h2);
    rd(8'h36, 16'hCB00, 2'h2);
    rd(8'h55, 16'hD3E0, 2'h2);
    rd(8'h58, 16'hCB26, 2'h2);
  endtask

  task automatic clr();
    @(posedge clk);
    clear_faults <= 1'b1;
    @(posedge clk);
    clear_faults <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic smp(input logic [15:0] v);
    @(posedge clk);
    vin_adc_valid <= 1'b1;
    vin_adc_code  <= v;
    @(posedge clk);
    vin_adc_valid <= 1'b0;
    vin_adc_code  <= ~v;
    repeat (5) @(posedge clk);
    #1;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    logic [15:0] d;
    logic [8:0]  e0 [7] = '{9'h000, 9'h05A, 9'h000, 9'h000, 9'h078, 9'h03C, 9'h078};
    logic [8:0]  e1 [7] = '{9'h0B4, 9'h10E, 9'h0F0, 9'h078, 9'h0F0, 9'h0F0, 9'h12C};
    logic [15:0] fw [10] = '{16'h0000, 16'hF3E8, 16'hFABC, 16'hFB52, 16'hFBE8,
                             16'h023F, 16'h028A, 16'h02EE, 16'h03E8, 16'h1234};
    logic [7:0]  th [4] = '{8'h35, 8'h36, 8'h55, 8'h58};
    srst = 1'b1;
    run_pin = 2'b00;
    chan_on_cmd = 2'b00;
    pll_locked_pin = 1'b0;
    clear_faults = 1'b0;
    vin_adc_valid = 1'b0;
    vin_adc_code = 16'h0000;
    do_reset();
    defaults();
    check(16'(share_oe), 16'h0001);
    for (int p = 0; p < 7; p++) begin
      d = {8'h00, 1'(p >> 2), 1'(p), 1'(p >> 1), 5'(16 + p)};
      wr(8'hF5, d, 1'b0);
      check(16'(ch0_deg), 16'(e0[p]));
      check(16'(ch1_deg), 16'(e1[p]));
      check(16'(ch0_rng), 16'(d[6]));
      check(16'(ch1_rng), 16'(d[5]));
      rd(8'hF5, d & 16'h007F, 2'h1);
    end
    wr(8'hF5, 16'h0017, 1'b0);
    check(16'(cml_f), 16'h0001);
    check(16'(ch1_deg), 16'h012C);
    clr();
    wr(8'hF5, 16'h0010, 1'b1);
    check(16'(cml_f), 16'h0001);
    rd(8'hF5, d & 16'h007F, 2'h1);
    clr();
    for (int i = 0; i < 10; i++) begin
      wr(8'h33, fw[i], 1'b0);
      check(freq_word, fw[i < 9 ? i : 8]);
      check(16'(ext_osc), 16'(i == 0));
      check(16'(pll_unl), 16'(i < 9));
      check(16'(cml_f), 16'(i == 9));
      pll_locked_pin <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      check(16'(pll_unl), 16'h0000);
      pll_locked_pin <= 1'b0;
      repeat (3) @(posedge clk);
    end
    run_pin <= 2'b10;
    chan_on_cmd <= 2'b10;
    repeat (4) @(posedge clk);
    wr(8'hF5, 16'h0000, 1'b0); // sent while running on purpose
    check(16'(busy_f), 16'h0001);
    clr();
    wr(8'h33, 16'hFBE8, 1'b0); // refused while running
    check(16'(busy_f), 16'h0001);
    check(16'(pll_unl), 16'h0000);
    rd(8'hF5, d & 16'h007F, 2'h1);
    rd(8'h33, 16'h03E8, 2'h2);
    for (int i = 0; i < 4; i++) begin
      wr(th[i], 16'hC000 + 16'(i), 1'b0);
      wr(th[i], 16'hAAAA, 1'b1);
      check(16'(cml_f), 16'h0001);
      rd(th[i], 16'hC000 + 16'(i), 2'h2);
    end
    do_reset();
    defaults();
    run_pin <= 2'b11;
    chan_on_cmd <= 2'b11;
    smp(16'hCB40);
    check(16'(conv_en), 16'h0003);
    smp(16'hD3E0);
    check(16'(share_oe), 16'h0000);
    check(16'(share_o), 16'h0000);
    check(16'(ov_f), 16'h0000);
    smp(16'hCB00);
    check(16'(conv_en), 16'h0000);
    check(16'(uv_w), 16'h0001);
    smp(16'hCA80);
    check(16'(share_oe), 16'h0001);
    smp(16'hDA00);
    check(16'(ov_f), 16'h0001);
    check(16'(conv_en), 16'h0003);
    clr();
    check(16'(ov_f | uv_w), 16'h0000);
    chan_on_cmd <= 2'b00;
    do_reset();
    wr(8'hF5, 16'h0000, 1'b0);
    chan_on_cmd <= 2'b11;
    check(16'(share_oe), 16'h0001);
    smp(16'hDA00);
    check(16'(share_oe), 16'h0000);
    smp(16'hCA80);
    check(16'(share_oe), 16'h0000);
    check(16'(conv_en), 16'h0000);
    summarize();
  end
endmodule
